// >>> core/usbrd_pkg.sv
// usbrd_pkg: constants, types and field layout of the redriver
// mode control block.
// assumes a single 100 MHz clock and the plain register port.
//
// Functional notes
// RULE1 - straps set gain and select control mode
// RULE2 - latch straps once, then drop bias resistors
// RULE3 - four levels decode to 00, 01, 10, 11
// RULE4 - setting is high code above low code
// RULE5 - two pins pick one of sixteen settings
// RULE6 - connector and system paths gained separately
// RULE7 - register mode uses the three gain registers
// RULE8 - equalizer off while LFPS is seen
// RULE9 - orientation from pin or register by mode
// RULE10 - enable low kills paths; orientation picks lane
// RULE11 - link state from physical conditions only
// RULE12 - enabled link in exactly one of four states
// RULE13 - repeat detection; found receiver enables termination
// RULE14 - stay disconnected until both ends terminate
// RULE15 - U0 redrives; both idle goes to U1
// RULE16 - U1 keeps terminations and common mode
// RULE17 - U2/U3 detects; missing termination disconnects
// RULE18 - U2/U3 goes to U0 on LFPS
// RULE19 - U2/U3 terminations on, common mode off
// RULE20 - disconnect detection interval at most 12 ms
// RULE21 - output idles within 10 ns of input; here redrive drops on the third clock edge after the input goes idle
// RULE22 - U1 exits to U0 or ages into U2/U3
// RULE23 - disable returns link to disconnect
package usbrd_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int T_CFG_HD_NS = 10000;
  localparam int CFG_HD_CYC = (T_CFG_HD_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RXDET_INTV_MS = 12;
  localparam int RXDET_CYC = T_RXDET_INTV_MS * 1000000 / CLK_NS;
  localparam int T_IDLE_ENTRY_NS = 10;
  localparam int IDLE_ENTRY_CYC = T_IDLE_ENTRY_NS / CLK_NS;
  localparam int STRAP_SETTLE_CYC = 3;
  localparam int U1_DWELL_CYC = 2000;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int AW = 4;
  localparam int DW = 8;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_GAIN_A = 4'h1;
  localparam logic [3:0] OFS_GAIN_B = 4'h2;
  localparam logic [3:0] OFS_GAIN_SYS = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_STRAP = 4'h5;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ORIENT_BIT = 1;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [3:0] RST_GAIN = 4'h0;
  // ------------------------------------------------------------
  // straps
  // ------------------------------------------------------------
  localparam int NSTRAP = 5;
  localparam int ST_CFG = 0;
  localparam int ST_RX_LO = 1;
  localparam int ST_RX_HI = 2;
  localparam int ST_SYS_LO = 3;
  localparam int ST_SYS_HI = 4;
  localparam logic [1:0] LVL_0 = 2'h0;
  // link states, gray along disc-u0-u1-u23
  typedef enum logic [1:0] {
    ST_DISC = 2'h0,
    ST_U0 = 2'h1,
    ST_U1 = 2'h3,
    ST_U23 = 2'h2
  } usbrd_state_e;
  typedef struct packed {
    logic far_term_ufp;
    logic far_term_dfp;
    logic rxdet_done;
    logic eidle_ufp;
    logic eidle_dfp;
    logic lfps;
  } usbrd_phy_s;
  typedef struct packed {
    logic [3:0] lane_a;
    logic [3:0] lane_b;
    logic [3:0] sys_tx;
  } usbrd_eq_s;
  typedef struct packed {
    logic lane_a_en;
    logic lane_b_en;
  } usbrd_route_s;
endpackage

// >>> core/usbrd_mode_ctrl.sv
// usbrd_mode_ctrl: strap capture, equalizer select, lane mux and
// link power state tracking of the redriver.
// assumes thermometer comparator outputs per strap pin and
// asynchronous phy status levels; one clock, plain register port.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module usbrd_mode_ctrl #(
  parameter int RXDET_CYC = usbrd_pkg::RXDET_CYC,
  parameter int U1_DWELL = usbrd_pkg::U1_DWELL_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [usbrd_pkg::NSTRAP-1:0][2:0] i_strap_lvl,
  input wire logic i_orient_pin,
  input wire logic i_path_enable_pin,
  input wire usbrd_pkg::usbrd_phy_s i_phy,
  input wire logic [usbrd_pkg::AW-1:0] i_addr,
  input wire logic [usbrd_pkg::DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [usbrd_pkg::DW-1:0] o_rdata,
  output logic o_strap_bias_en,
  output usbrd_pkg::usbrd_eq_s o_eq,
  output logic o_eq_en,
  output usbrd_pkg::usbrd_route_s o_route,
  output logic o_rxdet_req,
  output logic o_rx_term_en,
  output logic o_tx_cm_en,
  output logic o_redrive_en,
  output logic [1:0] o_link_state
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  localparam int NRAW = usbrd_pkg::NSTRAP * 3 + 8;
  localparam int CW = $clog2(RXDET_CYC + 1);
  localparam int HW = 12;
  localparam int UW = $clog2(U1_DWELL + 1);
  logic [NRAW-1:0] raw;
  logic [NRAW-1:0] meta_q;
  logic [NRAW-1:0] sync_q;
  assign raw = {i_strap_lvl, i_orient_pin, i_path_enable_pin, i_phy};
  // two flops per pin before any logic looks at it
  genvar k;
  generate
    for (k = 0; k < NRAW; k++) begin : g_sync
      always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          meta_q[k] <= 1'b0;
          sync_q[k] <= 1'b0;
        end else begin
          meta_q[k] <= raw[k];
          sync_q[k] <= meta_q[k];
        end
      end
    end
  endgenerate
  usbrd_pkg::usbrd_phy_s phy;
  logic orient_pin_s;
  logic path_en_pin_s;
  logic [usbrd_pkg::NSTRAP-1:0][2:0] lvl_s;
  assign phy = sync_q[5:0];
  assign path_en_pin_s = sync_q[6];
  assign orient_pin_s = sync_q[7];
  assign lvl_s = sync_q[NRAW-1:8];

  // ------------------------------------------------------------
  // strap decode and capture
  // ------------------------------------------------------------
  // level code is the number of tripped comparators
  logic [usbrd_pkg::NSTRAP-1:0][1:0] code;
  generate
    for (k = 0; k < usbrd_pkg::NSTRAP; k++) begin : g_dec
      assign code[k] = {1'b0, lvl_s[k][0]} + {1'b0, lvl_s[k][1]}
                     + {1'b0, lvl_s[k][2]}; // RULE3
    end
  endgenerate
  logic [HW-1:0] hd_cnt_q;
  logic strap_done_q;
  logic [usbrd_pkg::NSTRAP-1:0][1:0] strap_q;
  localparam logic [HW-1:0] LATCH_AT = HW'(usbrd_pkg::STRAP_SETTLE_CYC);
  localparam logic [HW-1:0] BIAS_OFF_AT =
    HW'(usbrd_pkg::STRAP_SETTLE_CYC + usbrd_pkg::CFG_HD_CYC);
  wire latch_now = (hd_cnt_q == LATCH_AT);
  wire hd_run = (hd_cnt_q != BIAS_OFF_AT);
  // count from reset release: latch once, then isolate bias
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hd_cnt_q <= '0;
      strap_done_q <= 1'b0;
      strap_q <= '0;
      o_strap_bias_en <= 1'b1;
    end else begin
      if (hd_run) hd_cnt_q <= hd_cnt_q + 1'b1;
      if (latch_now) begin
        strap_q <= code; // RULE2
        strap_done_q <= 1'b1;
      end
      if (!hd_run) o_strap_bias_en <= 1'b0; // RULE2
    end
  end
  // register mode when the config strap is not level 0
  wire reg_mode = strap_q[usbrd_pkg::ST_CFG] != usbrd_pkg::LVL_0; // RULE1
  wire [3:0] strap_rx_eq =
    {strap_q[usbrd_pkg::ST_RX_HI], strap_q[usbrd_pkg::ST_RX_LO]}; // RULE4
  wire [3:0] strap_sys_eq =
    {strap_q[usbrd_pkg::ST_SYS_HI], strap_q[usbrd_pkg::ST_SYS_LO]}; // RULE4

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic [3:0] gain_a_q;
  logic [3:0] gain_b_q;
  logic [3:0] gain_sys_q;
  usbrd_pkg::usbrd_state_e state_q;
  wire wr_ctrl = i_wr && (i_addr == usbrd_pkg::OFS_CTRL);
  wire wr_ga = i_wr && (i_addr == usbrd_pkg::OFS_GAIN_A);
  wire wr_gb = i_wr && (i_addr == usbrd_pkg::OFS_GAIN_B);
  wire wr_gs = i_wr && (i_addr == usbrd_pkg::OFS_GAIN_SYS);
  // software writes, read-only offsets ignore writes
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= usbrd_pkg::RST_CTRL;
      gain_a_q <= usbrd_pkg::RST_GAIN;
      gain_b_q <= usbrd_pkg::RST_GAIN;
      gain_sys_q <= usbrd_pkg::RST_GAIN;
    end else begin
      if (wr_ctrl) ctrl_q <= i_wdata[1:0];
      if (wr_ga) gain_a_q <= i_wdata[3:0];
      if (wr_gb) gain_b_q <= i_wdata[3:0];
      if (wr_gs) gain_sys_q <= i_wdata[3:0];
    end
  end
  // read mux, unmapped offsets read zero
  logic [usbrd_pkg::DW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (i_addr)
      usbrd_pkg::OFS_CTRL: rd_mux = {6'h00, ctrl_q};
      usbrd_pkg::OFS_GAIN_A: rd_mux = {4'h0, gain_a_q};
      usbrd_pkg::OFS_GAIN_B: rd_mux = {4'h0, gain_b_q};
      usbrd_pkg::OFS_GAIN_SYS: rd_mux = {4'h0, gain_sys_q};
      usbrd_pkg::OFS_STATUS: rd_mux = {3'h0, strap_done_q,
        o_strap_bias_en, reg_mode, state_q};
      usbrd_pkg::OFS_STRAP: rd_mux = {strap_sys_eq, strap_rx_eq};
      default: rd_mux = '0;
    endcase
  end
  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) o_rdata <= '0;
    else o_rdata <= i_rd ? rd_mux : '0;
  end

  // ------------------------------------------------------------
  // mode selection of enable, orientation and gains
  // ------------------------------------------------------------
  wire path_en = reg_mode ? ctrl_q[usbrd_pkg::CTRL_EN_BIT]
                          : path_en_pin_s;
  wire orient = reg_mode ? ctrl_q[usbrd_pkg::CTRL_ORIENT_BIT]
                         : orient_pin_s; // RULE9
  usbrd_pkg::usbrd_eq_s eq_sel;
  // connector lanes share the rx straps, system tx has its own
  assign eq_sel.lane_a = reg_mode ? gain_a_q : strap_rx_eq; // RULE6 RULE7
  assign eq_sel.lane_b = reg_mode ? gain_b_q : strap_rx_eq; // RULE7
  assign eq_sel.sys_tx = reg_mode ? gain_sys_q : strap_sys_eq; // RULE5
  usbrd_pkg::usbrd_route_s route_d;
  assign route_d.lane_a_en = path_en && !orient; // RULE10
  assign route_d.lane_b_en = path_en && orient; // RULE10
  // equalizer enable and lanes held off until straps are known; lfps turns equalizer off
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_eq <= '0;
      o_eq_en <= 1'b0;
      o_route <= '0;
    end else begin
      o_eq <= eq_sel;
      o_eq_en <= strap_done_q && !phy.lfps; // RULE8
      o_route <= strap_done_q ? route_d : '0;
    end
  end

  // ------------------------------------------------------------
  // link power state machine
  // ------------------------------------------------------------
  wire link_en = strap_done_q && path_en;
  wire both_idle = phy.eidle_ufp && phy.eidle_dfp; // RULE11
  wire both_term = phy.far_term_ufp && phy.far_term_dfp;
  logic [CW-1:0] det_cnt_q;
  logic [UW-1:0] u1_cnt_q;
  wire det_state = (state_q == usbrd_pkg::ST_DISC)
                || (state_q == usbrd_pkg::ST_U23);
  wire det_fire = link_en && det_state && (det_cnt_q == '0);
  wire u1_aged = (u1_cnt_q == UW'(U1_DWELL));
  usbrd_pkg::usbrd_state_e state_d;
  // next state from observed terminations, idle and lfps
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      usbrd_pkg::ST_DISC:
        if (phy.rxdet_done && both_term) state_d = usbrd_pkg::ST_U0; // RULE14
      usbrd_pkg::ST_U0:
        if (both_idle) state_d = usbrd_pkg::ST_U1; // RULE15 RULE21
      usbrd_pkg::ST_U1:
        if (!both_idle) state_d = usbrd_pkg::ST_U0; // RULE22
        else if (u1_aged) state_d = usbrd_pkg::ST_U23; // RULE22
      usbrd_pkg::ST_U23:
        if (phy.lfps) state_d = usbrd_pkg::ST_U0; // RULE18
        else if (phy.rxdet_done && !both_term)
          state_d = usbrd_pkg::ST_DISC; // RULE17
    endcase
    if (!link_en) state_d = usbrd_pkg::ST_DISC; // RULE23
  end
  // state, detection interval and u1 dwell counters
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= usbrd_pkg::ST_DISC;
      det_cnt_q <= '0;
      u1_cnt_q <= '0;
      o_rxdet_req <= 1'b0;
    end else begin
      state_q <= state_d; // RULE12
      o_rxdet_req <= det_fire; // RULE13
      if (!det_state || !link_en) det_cnt_q <= '0;
      else if (det_fire) det_cnt_q <= CW'(RXDET_CYC - 1); // RULE20
      else det_cnt_q <= det_cnt_q - 1'b1;
      if (state_q != usbrd_pkg::ST_U1) u1_cnt_q <= '0;
      else if (!u1_aged) u1_cnt_q <= u1_cnt_q + 1'b1;
    end
  end
  // per-state drive of terminations, common mode and redrive
  assign o_rx_term_en = state_q != usbrd_pkg::ST_DISC; // RULE13 RULE19
  assign o_tx_cm_en = (state_q == usbrd_pkg::ST_U0)
                   || (state_q == usbrd_pkg::ST_U1); // RULE16 RULE19
  assign o_redrive_en = state_q == usbrd_pkg::ST_U0; // RULE15
  assign o_link_state = state_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_found;
    link_en && phy.rxdet_done && both_term;
  endsequence
  sequence s_u23_lfps;
    link_en && state_q == usbrd_pkg::ST_U23 && phy.lfps;
  endsequence
  sequence s_latched;
    $rose(strap_done_q);
  endsequence
  strap_bias_a: assert property (s_latched |-> o_strap_bias_en ##1 // RULE2
    o_strap_bias_en [*8] ##[1:1000] !o_strap_bias_en)
    else $error("bias not removed after strap hold");
  disc_exit_a: assert property ( // RULE14
    state_q == usbrd_pkg::ST_DISC ##0 s_found |=>
    state_q == usbrd_pkg::ST_U0 && o_redrive_en)
    else $error("disconnect did not leave for U0");
  idle_entry_a: assert property ( // RULE21
    link_en && state_q == usbrd_pkg::ST_U0 && both_idle |=>
    !o_redrive_en && o_tx_cm_en)
    else $error("U0 did not idle into U1");
  u1_exit_a: assert property ( // RULE22
    link_en && state_q == usbrd_pkg::ST_U1 && !both_idle |=>
    state_q == usbrd_pkg::ST_U0)
    else $error("U1 did not return to U0");
  lfps_wake_a: assert property (s_u23_lfps |=> // RULE18
    state_q == usbrd_pkg::ST_U0 && o_redrive_en && o_tx_cm_en)
    else $error("lfps did not wake U2/U3");
  u23_drop_a: assert property ( // RULE17
    link_en && state_q == usbrd_pkg::ST_U23 && !phy.lfps &&
    phy.rxdet_done && !both_term |=>
    state_q == usbrd_pkg::ST_DISC && !o_rx_term_en)
    else $error("U2/U3 missed termination loss");
  disable_a: assert property (!link_en |=> // RULE23
    state_q == usbrd_pkg::ST_DISC && o_route == '0)
    else $error("disable did not reset link");
  route_a: assert property (strap_done_q && path_en |=> // RULE10
    o_route.lane_a_en == !$past(orient) && o_route.lane_b_en == $past(orient))
    else $error("lane route does not follow orientation");
  eq_lfps_a: assert property (phy.lfps |=> !o_eq_en) // RULE8
    else $error("equalizer left on during lfps");
  u23_cm_a: assert property (state_q == usbrd_pkg::ST_U23 |-> // RULE19
    o_rx_term_en && !o_tx_cm_en)
    else $error("U2/U3 termination or common mode wrong");
  det_disc_a: assert property ( // RULE20
    link_en && state_q == usbrd_pkg::ST_DISC && det_cnt_q == '0 |=>
    o_rxdet_req ##1 !o_rxdet_req)
    else $error("detection not requested on schedule");

  // ------------------------------------------------------------
  // assertions on straps, gains, lanes, link holding and read data
  // ------------------------------------------------------------
  // one u1 dwell step with both ports still idle
  sequence s_u1_idle;
    link_en && state_q == usbrd_pkg::ST_U1 && both_idle;
  endsequence

  strap_hold_a: assert property ( // RULE2
    strap_done_q |=> $stable(strap_q))
    else $error("straps changed after capture");

  code_zero_a: assert property ( // RULE3
    latch_now && lvl_s[usbrd_pkg::ST_SYS_HI] == 3'h0 |=>
    strap_q[usbrd_pkg::ST_SYS_HI] == 2'h0)
    else $error("level 0 strap not decoded to 00");

  code_r_a: assert property ( // RULE3
    latch_now && lvl_s[usbrd_pkg::ST_RX_LO] == 3'h1 |=>
    strap_q[usbrd_pkg::ST_RX_LO] == 2'h1)
    else $error("level R strap not decoded to 01");

  code_f_a: assert property ( // RULE3
    latch_now && lvl_s[usbrd_pkg::ST_RX_HI] == 3'h3 |=>
    strap_q[usbrd_pkg::ST_RX_HI] == 2'h2)
    else $error("level F strap not decoded to 10");

  code_one_a: assert property ( // RULE3
    latch_now && lvl_s[usbrd_pkg::ST_SYS_LO] == 3'h7 |=>
    strap_q[usbrd_pkg::ST_SYS_LO] == 2'h3)
    else $error("level 1 strap not decoded to 11");

  eq_pin_a: assert property ( // RULE4 RULE5 RULE6
    strap_done_q && !reg_mode |=>
    o_eq.lane_a == {strap_q[usbrd_pkg::ST_RX_HI],
    strap_q[usbrd_pkg::ST_RX_LO]} && o_eq.lane_b == o_eq.lane_a &&
    o_eq.sys_tx == {strap_q[usbrd_pkg::ST_SYS_HI],
    strap_q[usbrd_pkg::ST_SYS_LO]})
    else $error("strap gains not applied");

  eq_reg_a: assert property ( // RULE7
    strap_done_q && reg_mode |=> o_eq.lane_a == $past(gain_a_q) &&
    o_eq.lane_b == $past(gain_b_q) && o_eq.sys_tx == $past(gain_sys_q))
    else $error("register gains not applied");

  eq_on_a: assert property (strap_done_q && !phy.lfps |=> o_eq_en) // RULE8
    else $error("equalizer off without lfps");

  orient_pin_a: assert property ( // RULE9
    strap_done_q && !reg_mode && path_en_pin_s |=>
    o_route.lane_b_en == $past(orient_pin_s))
    else $error("pin mode ignores orientation pin");

  orient_reg_a: assert property ( // RULE9
    strap_done_q && reg_mode && ctrl_q[usbrd_pkg::CTRL_EN_BIT] |=>
    o_route.lane_b_en == $past(ctrl_q[usbrd_pkg::CTRL_ORIENT_BIT]))
    else $error("register mode ignores orientation bit");

  path_off_a: assert property (!path_en |=> o_route == '0) // RULE10
    else $error("lanes routed while path disabled");

  disc_dark_a: assert property ( // RULE13 RULE14
    state_q == usbrd_pkg::ST_DISC |-> !o_rx_term_en && !o_redrive_en)
    else $error("disconnect drives termination or lanes");

  disc_hold_a: assert property ( // RULE14
    link_en && state_q == usbrd_pkg::ST_DISC &&
    !(phy.rxdet_done && both_term) |=> state_q == usbrd_pkg::ST_DISC)
    else $error("disconnect left without both terminations");

  u0_hold_a: assert property ( // RULE15
    link_en && state_q == usbrd_pkg::ST_U0 && !both_idle |=>
    state_q == usbrd_pkg::ST_U0 && o_redrive_en)
    else $error("U0 left while traffic present");

  u1_keep_a: assert property ( // RULE16
    state_q == usbrd_pkg::ST_U1 |-> o_rx_term_en && o_tx_cm_en)
    else $error("U1 dropped termination or common mode");

  u1_wait_a: assert property (s_u1_idle ##0 !u1_aged |=> // RULE22
    state_q == usbrd_pkg::ST_U1)
    else $error("U1 left before its dwell");

  u1_age_a: assert property (s_u1_idle ##0 u1_aged |=> // RULE22
    state_q == usbrd_pkg::ST_U23)
    else $error("U1 did not age into U2/U3");

  u23_keep_a: assert property ( // RULE17
    link_en && state_q == usbrd_pkg::ST_U23 && !phy.lfps &&
    !phy.rxdet_done |=> state_q == usbrd_pkg::ST_U23)
    else $error("U2/U3 left without cause");

  det_u23_a: assert property ( // RULE17
    link_en && state_q == usbrd_pkg::ST_U23 && det_cnt_q == '0 |=>
    o_rxdet_req)
    else $error("U2/U3 skipped receiver detection");

  rd_idle_a: assert property (!i_rd |=> o_rdata == '0) // RULE7
    else $error("read data outside its cycle");
endmodule // usbrd_mode_ctrl
`default_nettype wire

// >>> sim/usbrd_phy_model.sv
// usbrd_phy_model: far side of the redriver link, both ports.
// assumes the bench sets presence, idle and lfps levels itself.
`timescale 1ns/1ps
`default_nettype none
module usbrd_phy_model #(
  parameter int DET_LAT = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_rxdet_req,
  input wire logic i_present,
  input wire logic [1:0] i_idle,
  input wire logic i_lfps,
  output usbrd_pkg::usbrd_phy_s o_phy
);
  int cnt_q;
  logic done_q;
  // answer each detection request after a fixed latency
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= 0;
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == 1);
      if (i_rxdet_req)
        cnt_q <= DET_LAT;
      else if (cnt_q != 0)
        cnt_q <= cnt_q - 1;
    end
  end
  // levels only, no traffic to decode
  assign o_phy = {i_present, i_present, done_q, i_idle, i_lfps};
endmodule // usbrd_phy_model
`default_nettype wire

// >>> sim/test_usb_redriver_mode_control.sv
// test_usb_redriver_mode_control: straps, lane mux, registers, link.
// assumes the design with short detection and dwell counts.
`timescale 1ns/1ps
`default_nettype none
module test_usb_redriver_mode_control;
  localparam int RXDET = 50;
  localparam int DWELL = 20;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [usbrd_pkg::NSTRAP-1:0][2:0] i_strap_lvl = '0;
  logic i_orient_pin = 1'b0;
  logic i_path_enable_pin = 1'b0;
  usbrd_pkg::usbrd_phy_s i_phy;
  logic [usbrd_pkg::AW-1:0] i_addr = '0;
  logic [usbrd_pkg::DW-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [usbrd_pkg::DW-1:0] o_rdata;
  logic o_strap_bias_en, o_eq_en, o_rxdet_req;
  logic o_rx_term_en, o_tx_cm_en, o_redrive_en;
  usbrd_pkg::usbrd_eq_s o_eq;
  usbrd_pkg::usbrd_route_s o_route;
  logic [1:0] o_link_state;
  logic present = 1'b0;
  logic [1:0] idle = 2'h0;
  logic lfps = 1'b0;
  logic [7:0] rd_q;
  int err_total = 0;
  int total_checks = 0;
  time t0;
  always #5 i_ref_clk = ~i_ref_clk;
  usbrd_mode_ctrl #(.RXDET_CYC(RXDET), .U1_DWELL(DWELL)) dut (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_strap_lvl(i_strap_lvl),
    .i_orient_pin(i_orient_pin), .i_path_enable_pin(i_path_enable_pin),
    .i_phy(i_phy), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_strap_bias_en(o_strap_bias_en),
    .o_eq(o_eq), .o_eq_en(o_eq_en), .o_route(o_route),
    .o_rxdet_req(o_rxdet_req), .o_rx_term_en(o_rx_term_en),
    .o_tx_cm_en(o_tx_cm_en), .o_redrive_en(o_redrive_en),
    .o_link_state(o_link_state));
  usbrd_phy_model #(.DET_LAT(2)) partner (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_rxdet_req(o_rxdet_req),
    .i_present(present), .i_idle(idle), .i_lfps(lfps), .o_phy(i_phy));
  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tmo();
    err_total++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    end_sim();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 rd_q = o_rdata;
  endtask
  task automatic wait_st(input logic [1:0] s);
    int n;
    n = 0;
    #1;
    while (o_link_state !== s && n < 400) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    if (o_link_state !== s) tmo();
  endtask
  task automatic wait_req();
    int n;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end while (o_rxdet_req !== 1'b1 && n < 200);
    if (o_rxdet_req !== 1'b1) tmo();
  endtask
  task automatic set_pins(input logic en, input logic ori);
    @(posedge i_ref_clk);
    i_path_enable_pin <= en;
    i_orient_pin <= ori;
    cyc(6);
  endtask
  task automatic do_reset(input logic [2:0] cfg);
    @(posedge i_ref_clk);
    i_nrst <= 1'b0;
    i_strap_lvl <= {3'h0, 3'h7, 3'h3, 3'h1, cfg}; // sys hi..cfg
    repeat (5) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    cyc(8);
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_pin();
    do_reset(3'h0);
    rd(usbrd_pkg::OFS_STRAP);
    chk(rd_q, 12'h039);
    rd(usbrd_pkg::OFS_STATUS);
    chk(rd_q[4:2], 3'h6);
    chk(o_eq, 12'h993);
    cyc(1000);
    chk(o_strap_bias_en, 1'b0);
    $display("test pin straps done");
  endtask
  task automatic t_route();
    set_pins(1'b0, 1'b1);
    chk(o_route, 2'h0);
    set_pins(1'b1, 1'b1);
    chk(o_route, 2'h1);
    set_pins(1'b1, 1'b0);
    chk(o_route, 2'h2);
    wait_req();
    t0 = $time;
    wait_req();
    chk(($time - t0) <= RXDET * 10, 1'b1);
    chk(o_link_state, usbrd_pkg::ST_DISC);
    $display("test route done");
  endtask
  task automatic t_link();
    @(posedge i_ref_clk);
    present <= 1'b1;
    wait_st(usbrd_pkg::ST_U0);
    chk({o_redrive_en, o_rx_term_en, o_tx_cm_en}, 3'h7);
    cyc(4);
    chk(o_eq_en, 1'b1);
    @(posedge i_ref_clk);
    idle <= 2'h3;
    wait_st(usbrd_pkg::ST_U1);
    chk({o_rx_term_en, o_tx_cm_en}, 2'h3);
    @(posedge i_ref_clk);
    idle <= 2'h1;
    wait_st(usbrd_pkg::ST_U0);
    chk({o_redrive_en, o_tx_cm_en}, 2'h3);
    @(posedge i_ref_clk);
    idle <= 2'h3;
    wait_st(usbrd_pkg::ST_U1);
    t0 = $time;
    wait_st(usbrd_pkg::ST_U23);
    chk(($time - t0) >= DWELL * 10, 1'b1);
    chk({o_rx_term_en, o_tx_cm_en}, 2'h2);
    @(posedge i_ref_clk);
    lfps <= 1'b1;
    wait_st(usbrd_pkg::ST_U0);
    chk(o_redrive_en, 1'b1);
    cyc(4);
    chk(o_eq_en, 1'b0);
    @(posedge i_ref_clk);
    lfps <= 1'b0;
    wait_st(usbrd_pkg::ST_U23);
    @(posedge i_ref_clk);
    present <= 1'b0;
    wait_st(usbrd_pkg::ST_DISC);
    chk({o_redrive_en, o_rx_term_en}, 2'h0);
    @(posedge i_ref_clk);
    present <= 1'b1;
    idle <= 2'h0;
    wait_st(usbrd_pkg::ST_U0);
    set_pins(1'b0, 1'b0);
    chk({o_link_state, o_route}, 4'h0);
    $display("test link done");
  endtask
  task automatic t_reg();
    do_reset(3'h7);
    rd(usbrd_pkg::OFS_STATUS);
    chk(rd_q[4:2], 3'h7);
    rd(usbrd_pkg::OFS_CTRL);
    chk(rd_q, 12'h000);
    wr(usbrd_pkg::OFS_GAIN_A, 8'h05);
    wr(usbrd_pkg::OFS_GAIN_B, 8'h0A);
    wr(usbrd_pkg::OFS_GAIN_SYS, 8'h0F);
    wr(4'h9, 8'hFF);
    rd(usbrd_pkg::OFS_GAIN_B);
    chk(rd_q, 12'h00A);
    cyc(1);
    chk(o_rdata, 12'h000);
    rd(4'h9);
    chk(rd_q, 12'h000);
    cyc(3);
    chk(o_eq, 12'h5AF);
    wr(usbrd_pkg::OFS_CTRL, 8'h03);
    cyc(6);
    chk(o_route, 2'h1);
    $display("test register mode done");
  endtask
  initial begin
    t_pin();
    t_route();
    t_link();
    t_reg();
    end_sim();
  end
endmodule // test_usb_redriver_mode_control
`default_nettype wire
